// [rtl/wig_consts.vh]
`ifndef WIG_CONSTS_VH
`define WIG_CONSTS_VH

// register byte offsets on the apb bus
`define WIG_ADDR_CTRL 8'h00
`define WIG_ADDR_STAT 8'h04
`define WIG_ADDR_MASK 8'h08
`define WIG_ADDR_W 8

// watchdog_control field layout
`define WIG_KEY_HI 7
`define WIG_KEY_LO 4
`define WIG_RUN_BIT 3
`define WIG_MODE_BIT 2
`define WIG_SEL_HI 1
`define WIG_SEL_LO 0
`define WIG_CTRL_RESET 8'h00

// mode encodings
`define WIG_MODE_WDOG 1'b0
`define WIG_MODE_TIMER 1'b1

// clear keys
`define WIG_KEY_FIRST 4'ha
`define WIG_KEY_SECOND 4'h5

// interval select codes and their expiry counts minus one
`define WIG_SEL_32768 2'h0
`define WIG_SEL_8192 2'h1
`define WIG_SEL_512 2'h2
`define WIG_SEL_64 2'h3
`define WIG_LAST_32768 15'h7fff
`define WIG_LAST_8192 15'h1fff
`define WIG_LAST_512 15'h01ff
`define WIG_LAST_64 15'h003f

// status bit position
`define WIG_STAT_EXPIRY 0

// key window: half of a 32.768 khz oscillator period (15258 ns) in 100 ns clocks
`define WIG_HALF_OSC_CYC 8'h98
`define WIG_WIN_W 8

`endif

// [rtl/wig_counter.v]
`timescale 1ns/1ns
`include "wig_consts.vh"

module wig_counter #(
  parameter CNT_W = 15
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // control
  input wire osc_tick,
  input wire run,
  input wire clear,
  input wire [1:0] sel,
  // result
  output reg expire_q
);

  reg [CNT_W-1:0] cnt_q;
  reg [CNT_W-1:0] cnt_d;

  // last count value before expiry for an interval code
  function [CNT_W-1:0] last_count;
    input [1:0] code;
    begin
      case (code)
        `WIG_SEL_32768: last_count = `WIG_LAST_32768;
        `WIG_SEL_8192: last_count = `WIG_LAST_8192;
        `WIG_SEL_512: last_count = `WIG_LAST_512;
        default: last_count = `WIG_LAST_64;
      endcase
    end
  endfunction

  // next count: clear first, then step per oscillator period
  always @* begin
    cnt_d = cnt_q;
    if (clear) begin
      cnt_d = {CNT_W{1'b0}};
    end else if (run && osc_tick) begin
      if (cnt_q == last_count(sel)) begin
        cnt_d = {CNT_W{1'b0}};
      end else begin
        cnt_d = cnt_q + {{(CNT_W-1){1'b0}}, 1'b1};
      end
    end
  end

  // count register and expiry pulse
  always @(posedge clk) begin
    if (!rstn) begin
      cnt_q <= {CNT_W{1'b0}};
      expire_q <= 1'b0;
    end else begin
      cnt_q <= cnt_d;
      expire_q <= !clear && run && osc_tick && (cnt_q == last_count(sel));
    end
  end

endmodule

// [rtl/wig_top.v]
// Decided for this implementation: the address map and the APB register port.
`timescale 1ns/1ns
`include "wig_consts.vh"

module wig_top #(
  parameter CNT_W = 15,
  parameter [`WIG_WIN_W-1:0] HALF_CYC = `WIG_HALF_OSC_CYC
) (
  // clock and reset
  input wire clk,
  input wire rstn,
  // apb slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [31:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata_q,
  output reg pready_q,
  output reg pslverr_q,
  // oscillator period strobe and power state
  input wire osc_tick,
  input wire deep_sleep,
  // system outputs
  output reg sys_reset_q,
  output reg irq_q
);

  // reset image of watchdog_control and window helpers
  localparam [7:0] CTRL_RST = `WIG_CTRL_RESET;
  localparam [`WIG_WIN_W-1:0] WIN_ZERO = {`WIG_WIN_W{1'b0}};
  localparam [`WIG_WIN_W-1:0] WIN_ONE = {{(`WIG_WIN_W-1){1'b0}}, 1'b1};

  // key sequencer states
  localparam [0:0] KS_IDLE = 1'b0;
  localparam [0:0] KS_ARMED = 1'b1;

  // watchdog_control fields
  reg run_q;
  reg run_d;
  reg mode_q;
  reg mode_d;
  reg [1:0] sel_q;
  reg [1:0] sel_d;
  reg [3:0] key_q;
  reg [3:0] key_d;
  // key sequencer and clear strobe
  reg ks_q;
  reg ks_d;
  reg [`WIG_WIN_W-1:0] win_q;
  reg [`WIG_WIN_W-1:0] win_d;
  reg clear_q;
  reg clear_d;
  // status and mask
  reg stat_q;
  reg stat_d;
  reg mask_q;
  reg mask_d;
  // next values of the registered outputs
  reg [31:0] prdata_d;
  reg pready_d;
  reg pslverr_d;
  reg sys_reset_d;
  reg irq_d;
  // bus and control decode
  wire expire;
  wire [`WIG_ADDR_W-1:0] addr;
  wire setup;
  wire done;
  wire wr;
  wire rd;
  wire in_page;
  wire hit;
  wire wr_ctrl;
  wire wr_mask;
  wire rd_stat;
  wire [3:0] key_in;
  wire wdog_locked;
  wire key_ok;
  wire timer_clear;
  wire [7:0] ctrl_word;

  // true when an in-page address selects the given register
  function reg_match;
    input [`WIG_ADDR_W-1:0] a;
    input [`WIG_ADDR_W-1:0] target;
    input in_range;
    begin
      reg_match = in_range && (a == target);
    end
  endfunction

  // read data mux for the current address
  function [31:0] read_word;
    input [`WIG_ADDR_W-1:0] a;
    input [7:0] ctrl;
    input st;
    input mk;
    begin
      case (a)
        `WIG_ADDR_CTRL: read_word = {24'h000000, ctrl};
        `WIG_ADDR_STAT: read_word = {31'h00000000, st};
        `WIG_ADDR_MASK: read_word = {31'h00000000, mk};
        default: read_word = 32'h00000000;
      endcase
    end
  endfunction

  // bus phase decode
  assign addr = paddr[`WIG_ADDR_W-1:0];
  assign setup = psel && !penable;
  assign done = psel && penable && pready_q;
  assign wr = done && pwrite;
  assign rd = done && !pwrite;
  assign in_page = (paddr[31:`WIG_ADDR_W] == {(32-`WIG_ADDR_W){1'b0}});
  assign hit = reg_match(addr, `WIG_ADDR_CTRL, in_page) ||
               reg_match(addr, `WIG_ADDR_STAT, in_page) ||
               reg_match(addr, `WIG_ADDR_MASK, in_page);
  assign wr_ctrl = wr && reg_match(addr, `WIG_ADDR_CTRL, in_page);
  assign wr_mask = wr && reg_match(addr, `WIG_ADDR_MASK, in_page);
  assign rd_stat = rd && reg_match(addr, `WIG_ADDR_STAT, in_page);

  // control write decode
  assign key_in = pwdata[`WIG_KEY_HI:`WIG_KEY_LO];
  assign wdog_locked = run_q && (mode_q == `WIG_MODE_WDOG);
  assign key_ok = (ks_q == KS_ARMED) && (key_in == `WIG_KEY_SECOND);
  assign timer_clear = (mode_q == `WIG_MODE_TIMER) && pwdata[`WIG_KEY_LO];
  assign ctrl_word = {key_q, run_q, mode_q, sel_q};

  // next watchdog_control fields on a control write
  always @* begin
    run_d = run_q;
    mode_d = mode_q;
    sel_d = sel_q;
    key_d = key_q;
    if (wr_ctrl) begin
      sel_d = pwdata[`WIG_SEL_HI:`WIG_SEL_LO];
      if (!wdog_locked) begin
        mode_d = pwdata[`WIG_MODE_BIT];
      end
      if (pwdata[`WIG_RUN_BIT]) begin
        run_d = 1'b1;
      end else if (!wdog_locked) begin
        run_d = 1'b0;
      end
      if (run_q) begin
        key_d = key_in;
      end
    end
  end

  // key sequencer: first key arms a window of half an oscillator period
  always @* begin
    ks_d = ks_q;
    win_d = win_q;
    case (ks_q)
      KS_IDLE: begin
        win_d = WIN_ZERO;
      end
      KS_ARMED: begin
        if (win_q <= WIN_ONE) begin
          ks_d = KS_IDLE;
          win_d = WIN_ZERO;
        end else begin
          win_d = win_q - WIN_ONE;
        end
      end
      default: begin
        ks_d = KS_IDLE;
        win_d = WIN_ZERO;
      end
    endcase
    if (wr_ctrl && run_q) begin
      if (key_in == `WIG_KEY_FIRST) begin
        ks_d = KS_ARMED;
        win_d = HALF_CYC;
      end else begin
        ks_d = KS_IDLE;
        win_d = WIN_ZERO;
      end
    end
  end

  // counter clear: restart from stopped, keyed clear, timer-mode clear
  always @* begin
    clear_d = 1'b0;
    if (wr_ctrl) begin
      if (pwdata[`WIG_RUN_BIT] && !run_q) begin
        clear_d = 1'b1;
      end
      if (run_q && (key_ok || timer_clear)) begin
        clear_d = 1'b1;
      end
    end
  end

  // sticky expiry flag: set wins over the read that clears it
  always @* begin
    stat_d = stat_q;
    mask_d = mask_q;
    if (wr_mask) begin
      mask_d = pwdata[`WIG_STAT_EXPIRY];
    end
    if (expire && (mode_q == `WIG_MODE_TIMER)) begin
      stat_d = 1'b1;
    end else if (rd_stat && prdata_q[`WIG_STAT_EXPIRY]) begin
      stat_d = 1'b0; // only a flag that was read out is cleared
    end
  end

  // apb answer: one access cycle, error and zero data off the map
  always @* begin
    pready_d = setup;
    pslverr_d = setup && !hit;
    prdata_d = prdata_q;
    if (setup) begin
      prdata_d = hit ? read_word(addr, ctrl_word, stat_q, mask_q) : 32'h00000000;
    end
  end

  // system reset in watchdog mode, interrupt level in timer mode
  always @* begin
    sys_reset_d = expire && (mode_q == `WIG_MODE_WDOG);
    irq_d = stat_q && mask_q;
  end

  // bus answer registers
  always @(posedge clk) begin
    if (!rstn) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= 32'h00000000;
    end else begin
      pready_q <= pready_d;
      pslverr_q <= pslverr_d;
      prdata_q <= prdata_d;
    end
  end

  // watchdog_control registers, timer off after reset
  always @(posedge clk) begin
    if (!rstn) begin
      run_q <= CTRL_RST[`WIG_RUN_BIT];
      mode_q <= CTRL_RST[`WIG_MODE_BIT];
      sel_q <= CTRL_RST[`WIG_SEL_HI:`WIG_SEL_LO];
      key_q <= CTRL_RST[`WIG_KEY_HI:`WIG_KEY_LO];
    end else begin
      run_q <= run_d;
      mode_q <= mode_d;
      sel_q <= sel_d;
      key_q <= key_d;
    end
  end

  // key sequencer and clear strobe registers
  always @(posedge clk) begin
    if (!rstn) begin
      ks_q <= KS_IDLE;
      win_q <= WIN_ZERO;
      clear_q <= 1'b0;
    end else begin
      ks_q <= ks_d;
      win_q <= win_d;
      clear_q <= clear_d;
    end
  end

  // status, mask, interrupt and system reset registers
  always @(posedge clk) begin
    if (!rstn) begin
      stat_q <= 1'b0;
      mask_q <= 1'b0;
      irq_q <= 1'b0;
      sys_reset_q <= 1'b0;
    end else begin
      stat_q <= stat_d;
      mask_q <= mask_d;
      irq_q <= irq_d;
      sys_reset_q <= sys_reset_d;
    end
  end

  // expiry counter on the oscillator strobe, held at zero in deep sleep
  wig_counter #(
    .CNT_W(CNT_W)
  ) u_cnt (
    .clk(clk),
    .rstn(rstn),
    .osc_tick(osc_tick),
    .run(run_q && !deep_sleep),
    .clear(clear_q || deep_sleep),
    .sel(sel_q),
    .expire_q(expire)
  );

endmodule

// [bench/wig_properties.sv]
`timescale 1ns/1ns
module wig_chk (
  // watched ports
  input wire clk,
  input wire rstn,
  input wire psel,
  input wire penable,
  input wire [31:0] paddr,
  input wire pready_q,
  input wire pslverr_q,
  input wire osc_tick,
  input wire deep_sleep,
  input wire sys_reset_q,
  input wire irq_q
);
  // setup phase of a bus transfer
  wire setup_w = psel && !penable;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  AST_RDY: assert property (setup_w |=> pready_q)
    else $error("no ready after setup");
  AST_ONE: assert property (pready_q |=> !pready_q)
    else $error("ready held too long");
  AST_BAD: assert property (setup_w && paddr > 32'h8 |=> pslverr_q)
    else $error("unmapped address accepted");
  AST_GOOD: assert property (setup_w && paddr == 32'h0 |=> !pslverr_q)
    else $error("control access refused");
  AST_TICK: assert property (sys_reset_q |-> $past(osc_tick, 2))
    else $error("reset pulse without tick");
  AST_GAP: assert property (sys_reset_q |=> !sys_reset_q [*8])
    else $error("reset pulses too close");
  AST_SLP: assert property (deep_sleep [*2] |=> !sys_reset_q)
    else $error("reset while asleep");
  AST_IDLE: assert property ($rose(rstn) |-> !irq_q && !sys_reset_q)
    else $error("outputs active after reset");
  // main scenarios
  cover property (sys_reset_q);
  cover property ($rose(irq_q));
  cover property (setup_w && paddr == 32'h4);
endmodule
bind wig_top wig_chk u_chk (.clk, .rstn, .psel, .penable, .paddr, .pready_q, .pslverr_q,
  .osc_tick, .deep_sleep, .sys_reset_q, .irq_q);

// [bench/testbench.sv]
`timescale 1ns/1ns
module testbench;
  reg clk = 0, rstn = 0, psel = 0, penable = 0, pwrite = 0, osc_tick = 0, deep_sleep = 0;
  reg [31:0] paddr = 0, pwdata = 0, rd = 0;
  reg err = 0;
  reg fast = 0;
  wire [31:0] prdata_q;
  wire pready_q, pslverr_q, sys_reset_q, irq_q;
  integer n_errors = 0, samples_checked = 0, cyc = 0, n_rst = 0, k = 0;
  // short key window keeps the slow-key case brief
  wig_top #(.HALF_CYC(8'd3)) uut (.clk, .rstn, .psel, .penable, .pwrite, .paddr, .pwdata,
    .prdata_q, .pready_q, .pslverr_q, .osc_tick, .deep_sleep, .sys_reset_q, .irq_q);
  initial forever #50 clk = ~clk;
  // tick every other cycle (every cycle when fast), reset pulse tally, timeout
  always @(posedge clk) begin
    osc_tick <= fast | ~osc_tick;
    cyc <= cyc + 1;
    if (sys_reset_q === 1'b1) n_rst <= n_rst + 1;
    if (cyc == 60000) begin
      n_errors = n_errors + 1;
      print_verdict;
    end
  end
  task print_verdict;
    begin
      if (n_errors == 0 && samples_checked > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  task cmp(input [31:0] got, input [31:0] exp);
    begin
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
        n_errors = n_errors + 1;
        $display("mismatch %0t got %h exp %h", $time, got, exp);
      end
    end
  endtask
  task idle(input integer n);
    repeat (n) @(posedge clk);
  endtask
  // one bus transfer, held until ready
  task apb(input w, input [31:0] a, input [31:0] d);
    begin
      @(posedge clk);
      psel <= 1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1;
      @(posedge clk);
      while (pready_q !== 1'b1) @(posedge clk);
      rd = prdata_q;
      err = pslverr_q;
      psel <= 0;
      penable <= 0;
    end
  endtask
  // timer-mode interval with a tick every cycle, exact to one cycle
  task interval(input [7:0] ctrl, input integer n);
    begin
      apb(1, 0, 32'h04);
      apb(0, 4, 0);
      apb(1, 0, {24'h000000, ctrl});
      idle(n + 3); cmp(irq_q, 0);
      idle(1); cmp(irq_q, 1);
    end
  endtask
  initial begin
    idle(20);
    rstn <= 1;
    apb(0, 0, 0); cmp(rd, 0);
    apb(0, 32'hc, 0); cmp(err, 1);
    apb(1, 0, 32'h0b);
    apb(1, 0, 32'h07);
    apb(0, 0, 0); cmp(rd & 32'hf, 32'hb);
    repeat (8) begin
      idle(40); apb(1, 0, 32'hab); apb(1, 0, 32'h5b);
    end
    cmp(n_rst, 0);
    repeat (8) begin
      idle(40); apb(1, 0, 32'hab); idle(10); apb(1, 0, 32'h5b);
    end
    cmp(n_rst > 1, 1);
    apb(0, 4, 0); cmp(rd, 0);
    rstn <= 0;
    idle(2);
    rstn <= 1;
    k = n_rst;
    apb(1, 0, 32'ha4);
    apb(0, 0, 0); cmp(rd & 32'hff, 32'h04);
    apb(1, 8, 1);
    apb(1, 0, 32'h0f);
    idle(140); cmp(irq_q, 1);
    apb(0, 4, 0); cmp(rd, 1);
    idle(2); cmp(irq_q, 0);
    cmp(n_rst, k);
    apb(1, 0, 32'h07);
    idle(300);
    apb(0, 4, 0); cmp(rd, 0);
    apb(1, 0, 32'h0f);
    deep_sleep <= 1;
    idle(300);
    apb(0, 4, 0); cmp(rd, 0);
    deep_sleep <= 0;
    idle(140); cmp(irq_q, 1);
    fast <= 1;
    interval(8'h0f, 64);
    interval(8'h0e, 512);
    interval(8'h0d, 8192);
    interval(8'h0c, 32768);
    print_verdict;
  end
endmodule
